/* pfsw_top.sv */
// Flash program memory read, row erase and self-write controller behind AXI4-Lite
// Functional notes
// - Word address from high and low bytes
// - Start bits set by software, cleared by hardware
// - Erase or write only while permit set
// - System reset during write sets error flag, power reset clears it
// - Unlock register reads back as zero
// - Row is the smallest erased region
// - Hidden latches loaded only through data pair
// - Read fetches in second slot, ignores it
// - Data pair holds until read or write
// - Unlock 55h then AAh, then write start
// - Every erase, load, program needs unlock
// - Write start forces two no-op slots
// - Erase or program stalls processor about 2 ms
// - Latch load adds no stall
// - Erase clears whole row holding address
// - Resume at third instruction after start
// - Latch-only select loads, else programs row
// - Sixteen row-aligned latches, low bits select
// - Latches blank after every erase or program
`timescale 1ns/1ns
`default_nettype none
module pfsw_top #(
	parameter int unsigned PROG_CYCLES = pfsw_pkg::PROG_CYCLES_DEF
) (
	input  wire logic                        CLOCK,
	input  wire logic                        SYS_RST,
	input  wire logic                        PWR_RST,
	input  wire logic [pfsw_pkg::AXI_AW-1:0] S_AXI_AWADDR,
	input  wire logic                        S_AXI_AWVALID,
	output var  logic                        S_AXI_AWREADY,
	input  wire logic [pfsw_pkg::AXI_DW-1:0] S_AXI_WDATA,
	input  wire logic [3:0]                  S_AXI_WSTRB,
	input  wire logic                        S_AXI_WVALID,
	output var  logic                        S_AXI_WREADY,
	output var  logic [1:0]                  S_AXI_BRESP,
	output var  logic                        S_AXI_BVALID,
	input  wire logic                        S_AXI_BREADY,
	input  wire logic [pfsw_pkg::AXI_AW-1:0] S_AXI_ARADDR,
	input  wire logic                        S_AXI_ARVALID,
	output var  logic                        S_AXI_ARREADY,
	output var  logic [pfsw_pkg::AXI_DW-1:0] S_AXI_RDATA,
	output var  logic [1:0]                  S_AXI_RRESP,
	output var  logic                        S_AXI_RVALID,
	input  wire logic                        S_AXI_RREADY,
	output var  pfsw_pkg::pfsw_flash_t       FLASH_REQ,
	input  wire logic [pfsw_pkg::WORD_W-1:0] FLASH_RDATA,
	output var  pfsw_pkg::pfsw_cpu_t         CPU_CTL
);
	import pfsw_pkg::*;

	logic                 aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [AXI_AW-1:0]    awaddr_q, awaddr_d;
	logic [7:0]           wbyte_q, wbyte_d;
	logic                 wlane_q, wlane_d;
	logic                 awready_q, awready_d, wready_q, wready_d;
	logic                 bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0]           bresp_q, bresp_d, rresp_q, rresp_d;
	logic [AXI_DW-1:0]    rdata_q, rdata_d;
	logic                 wr_fire, wr_mapped, reg_we, rd_mapped;
	logic [AXI_DW-1:0]    rd_val;

	logic [7:0]           adr_lo_q, adr_lo_d;
	logic [ADRH_W-1:0]    adr_hi_q, adr_hi_d;
	logic [7:0]           dat_lo_q, dat_lo_d;
	logic [DATH_W-1:0]    dat_hi_q, dat_hi_d;
	pfsw_ctl_t            ctl_q, ctl_d, ctl_rst, wctl;
	pfsw_unlock_t         ulk_q, ulk_d;
	pfsw_state_t          state_q, state_d;
	logic [TMR_W-1:0]     tmr_q, tmr_d;
	logic [LIDX_W-1:0]    idx_q, idx_d;
	pfsw_flash_t          flash_q, flash_d;
	pfsw_cpu_t            cpu_q, cpu_d;
	logic                 lat_load, lat_blank;
	pfsw_latch_arr_t      lat_words;
	logic [ADDR_W-1:0]    word_addr;
	logic [WORD_W-1:0]    wr_word;
	logic [LIDX_W-1:0]    latch_idx;

	assign word_addr = {adr_hi_q, adr_lo_q};
	assign wr_word   = {dat_hi_q, dat_lo_q};
	assign latch_idx = word_addr[LIDX_W-1:0];
	assign wctl      = pfsw_ctl_t'(wbyte_q[CTL_W-1:0]);

	always_comb
	begin
		case (awaddr_q)
			OFS_ADDR_LOW, OFS_ADDR_HIGH, OFS_DATA_LOW, OFS_DATA_HIGH,
			OFS_CONTROL, OFS_UNLOCK: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
		rd_mapped = 1'b1;
		rd_val    = '0;
		case (S_AXI_ARADDR)
			OFS_ADDR_LOW:  rd_val[7:0] = adr_lo_q;
			OFS_ADDR_HIGH: rd_val[ADRH_W-1:0] = adr_hi_q;
			OFS_DATA_LOW:  rd_val[7:0] = dat_lo_q;
			OFS_DATA_HIGH: rd_val[DATH_W-1:0] = dat_hi_q;
			OFS_CONTROL:   rd_val[CTL_W-1:0] = ctl_q;
			OFS_UNLOCK:    rd_val = '0;
			default:       rd_mapped = 1'b0;
		endcase
	end

	// Bus slave: address and data may arrive in either order, one write in flight
	always_comb
	begin
		aw_held_d = aw_held_q;
		w_held_d  = w_held_q;
		awaddr_d  = awaddr_q;
		wbyte_d   = wbyte_q;
		wlane_d   = wlane_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		wr_fire   = aw_held_q && w_held_q && !bvalid_q;
		reg_we    = wr_fire && wr_mapped && wlane_q;
		if (S_AXI_AWVALID && awready_q)
		begin
			aw_held_d = 1'b1;
			awaddr_d  = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && wready_q)
		begin
			w_held_d = 1'b1;
			wbyte_d  = S_AXI_WDATA[7:0];
			wlane_d  = S_AXI_WSTRB[0];
		end
		if (bvalid_q && S_AXI_BREADY)
			bvalid_d = 1'b0;
		if (wr_fire)
		begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_q && S_AXI_RREADY)
			rvalid_d = 1'b0;
		if (S_AXI_ARVALID && arready_q)
		begin
			rvalid_d = 1'b1;
			rdata_d  = rd_val;
			rresp_d  = rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		awready_d = !aw_held_d && !bvalid_d;
		wready_d  = !w_held_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST || PWR_RST)
		begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= '0;
			wbyte_q   <= '0;
			wlane_q   <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= '0;
		end
		else
		begin
			aw_held_q <= aw_held_d;
			w_held_q  <= w_held_d;
			awaddr_q  <= awaddr_d;
			wbyte_q   <= wbyte_d;
			wlane_q   <= wlane_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
		end
	end

	// Registers, unlock tracker and sequencer
	always_comb
	begin
		adr_lo_d  = adr_lo_q;
		adr_hi_d  = adr_hi_q;
		dat_lo_d  = dat_lo_q;
		dat_hi_d  = dat_hi_q;
		ctl_d     = ctl_q;
		ulk_d     = ulk_q;
		state_d   = state_q;
		tmr_d     = tmr_q;
		idx_d     = idx_q;
		flash_d   = '0;
		lat_load  = 1'b0;
		lat_blank = 1'b0;
		// Any other write to a mapped register between the keys breaks the sequence
		if (reg_we)
		begin
			ulk_d = UL_IDLE;
			case (awaddr_q)
				OFS_ADDR_LOW:  adr_lo_d = wbyte_q;
				OFS_ADDR_HIGH: adr_hi_d = wbyte_q[ADRH_W-1:0];
				OFS_DATA_LOW:  dat_lo_d = wbyte_q;
				OFS_DATA_HIGH: dat_hi_d = wbyte_q[DATH_W-1:0];
				OFS_CONTROL:
				begin
					ctl_d.cfg    = wctl.cfg;
					ctl_d.erase  = wctl.erase;
					ctl_d.latch_only_select   = wctl.latch_only_select;
					ctl_d.permit = wctl.permit;
					ctl_d.err    = wctl.err;
					// Start bits can only be set here, never cleared
					if (state_q == ST_IDLE && !wctl.cfg)
					begin
						if (wctl.wr && ulk_q == UL_KEY2)
							ctl_d.wr = 1'b1;
						else if (wctl.rd)
							ctl_d.rd = 1'b1;
					end
				end
				OFS_UNLOCK:
				begin
					if (wbyte_q == UNLOCK_KEY1)
						ulk_d = UL_KEY1;
					else if (wbyte_q == UNLOCK_KEY2 && ulk_q == UL_KEY1)
						ulk_d = UL_KEY2;
				end
				default: ulk_d = UL_IDLE;
			endcase
		end
		case (state_q)
			ST_IDLE:
			begin
				if (ctl_d.wr && !ctl_q.wr)
					state_d = ST_WR_NOP1;
				else if (ctl_d.rd && !ctl_q.rd)
					state_d = ST_RD_SLOT;
			end
			ST_RD_SLOT:
			begin
				state_d      = ST_RD_FETCH;
				flash_d.rd   = 1'b1;
				flash_d.addr = word_addr;
			end
			ST_RD_FETCH:
			begin
				{dat_hi_d, dat_lo_d} = FLASH_RDATA;
				ctl_d.rd = 1'b0;
				state_d  = ST_IDLE;
			end
			ST_WR_NOP1: state_d = ST_WR_NOP2;
			ST_WR_NOP2:
			begin
				if (!ctl_q.permit)
				begin
					ctl_d.wr = 1'b0;
					state_d  = ST_IDLE;
				end
				else if (ctl_q.erase)
				begin
					state_d       = ST_ERASE;
					flash_d.erase = 1'b1;
					flash_d.addr  = {word_addr[ADDR_W-1:LIDX_W], {LIDX_W{1'b0}}};
				end
				else if (ctl_q.latch_only_select)
				begin
					lat_load = 1'b1;
					ctl_d.wr = 1'b0;
					state_d  = ST_IDLE;
				end
				else
				begin
					state_d = ST_PROG;
					idx_d   = '0;
				end
			end
			ST_ERASE:
			begin
				state_d = ST_BUSY;
				tmr_d   = TMR_W'(PROG_CYCLES - 1);
			end
			ST_PROG:
			begin
				flash_d.prog_we = 1'b1;
				flash_d.addr    = {word_addr[ADDR_W-1:LIDX_W], idx_q};
				flash_d.wdata   = lat_words[idx_q];
				idx_d           = idx_q + 1'b1;
				if (idx_q == LIDX_W'(LATCH_N - 1))
				begin
					state_d = ST_BUSY;
					tmr_d   = TMR_W'(PROG_CYCLES - 1);
				end
			end
			ST_BUSY:
			begin
				if (tmr_q == '0)
				begin
					ctl_d.wr  = 1'b0;
					lat_blank = 1'b1;
					state_d   = ST_IDLE;
				end
				else
					tmr_d = tmr_q - 1'b1;
			end
			default: state_d = ST_IDLE;
		endcase
		cpu_d.force_nop   = state_d == ST_WR_NOP1 || state_d == ST_WR_NOP2;
		cpu_d.ignore_slot = state_d == ST_RD_FETCH;
		cpu_d.stall       = state_d == ST_ERASE || state_d == ST_PROG
			|| state_d == ST_BUSY;
		// Warm reset keeps evidence of a write it cut short
		ctl_rst     = CTL_RST;
		ctl_rst.err = ctl_q.err || ctl_q.wr;
	end

	always_ff @(posedge CLOCK)
	begin
		if (PWR_RST || SYS_RST)
		begin
			adr_lo_q <= '0;
			adr_hi_q <= '0;
			dat_lo_q <= '0;
			dat_hi_q <= '0;
			ctl_q    <= PWR_RST ? CTL_RST : ctl_rst;
			ulk_q    <= UL_IDLE;
			state_q  <= ST_IDLE;
			tmr_q    <= '0;
			idx_q    <= '0;
			flash_q  <= '0;
			cpu_q    <= '0;
		end
		else
		begin
			adr_lo_q <= adr_lo_d;
			adr_hi_q <= adr_hi_d;
			dat_lo_q <= dat_lo_d;
			dat_hi_q <= dat_hi_d;
			ctl_q    <= ctl_d;
			ulk_q    <= ulk_d;
			state_q  <= state_d;
			tmr_q    <= tmr_d;
			idx_q    <= idx_d;
			flash_q  <= flash_d;
			cpu_q    <= cpu_d;
		end
	end

	pfsw_latch_bank u_latches (
		.clk   (CLOCK),
		.rst   (SYS_RST || PWR_RST),
		.load  (lat_load),
		.blank (lat_blank),
		.idx   (latch_idx),
		.wdata (wr_word),
		.words (lat_words)
	);

	assign S_AXI_AWREADY = awready_q;
	assign S_AXI_WREADY  = wready_q;
	assign S_AXI_BVALID  = bvalid_q;
	assign S_AXI_BRESP   = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID  = rvalid_q;
	assign S_AXI_RRESP   = rresp_q;
	assign S_AXI_RDATA   = rdata_q;
	assign FLASH_REQ     = flash_q;
	assign CPU_CTL       = cpu_q;

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST || PWR_RST);

	sequence s_rd_go;
		state_q == ST_IDLE && state_d == ST_RD_SLOT;
	endsequence
	sequence s_wr_go;
		state_q == ST_IDLE && state_d == ST_WR_NOP1;
	endsequence
	sequence s_rd_slots;
		!cpu_q.ignore_slot ##1 cpu_q.ignore_slot && flash_q.rd ##1 !ctl_q.rd;
	endsequence

	a_rd_second_slot: assert property (s_rd_go |=> s_rd_slots)
		else $error("read fetch not in second slot");
	a_rd_data_kept: assert property (state_q == ST_RD_FETCH |=>
		wr_word == $past(FLASH_RDATA) ##1 ($past(reg_we) || $stable(wr_word)))
		else $error("fetched word not held");
	a_wr_two_nops: assert property (s_wr_go |=> cpu_q.force_nop [*2] ##1 !cpu_q.force_nop)
		else $error("write start did not force two no-ops");
	a_wr_unlocked: assert property ($rose(ctl_q.wr) |-> $past(ulk_q) == UL_KEY2)
		else $error("write start set without unlock");
	a_permit_gate: assert property (state_q == ST_WR_NOP2 && !ctl_q.permit |=>
		state_q == ST_IDLE && !ctl_q.wr && !flash_q.erase && !cpu_q.stall)
		else $error("operation ran without permit");
	a_load_no_stall: assert property (state_q == ST_WR_NOP2 && ctl_q.permit && !ctl_q.erase
		&& ctl_q.latch_only_select |=> !cpu_q.stall && !ctl_q.wr
		&& lat_words[$past(latch_idx)] == $past(wr_word))
		else $error("latch load stalled or lost data");
	a_erase_row: assert property ($rose(flash_q.erase) |->
		flash_q.addr[LIDX_W-1:0] == '0 && cpu_q.stall)
		else $error("erase not row aligned or not stalled");
	a_busy_end: assert property (state_q == ST_BUSY && tmr_q == '0 |=> !cpu_q.stall
		&& !ctl_q.wr && lat_words[0] == BLANK_WORD
		&& lat_words[LATCH_N-1] == BLANK_WORD)
		else $error("latches not blank or stall held after operation");
	a_unlock_reads_zero: assert property (S_AXI_ARVALID && arready_q
		&& S_AXI_ARADDR == OFS_UNLOCK |=> rvalid_q && rdata_q == '0)
		else $error("unlock register read not zero");
	a_err_on_reset: assert property (@(posedge CLOCK) disable iff (PWR_RST)
		SYS_RST && ctl_q.wr |=> ctl_q.err && !ctl_q.permit)
		else $error("reset during write did not flag error");
endmodule
`default_nettype wire

/* pfsw_pkg.sv */
// Constants, layouts and types shared by the flash self-write controller
`default_nettype none
package pfsw_pkg;
	localparam int unsigned AXI_AW   = 8;
	localparam int unsigned AXI_DW   = 32;
	localparam int unsigned ADDR_W   = 14;
	localparam int unsigned ADRH_W   = 6;
	localparam int unsigned WORD_W   = 14;
	localparam int unsigned DATH_W   = 6;
	localparam int unsigned LATCH_N  = 16;
	localparam int unsigned LIDX_W   = 4;
	localparam int unsigned CTL_W    = 7;

	localparam logic [AXI_AW-1:0] OFS_ADDR_LOW  = 8'h00;
	localparam logic [AXI_AW-1:0] OFS_ADDR_HIGH = 8'h04;
	localparam logic [AXI_AW-1:0] OFS_DATA_LOW  = 8'h08;
	localparam logic [AXI_AW-1:0] OFS_DATA_HIGH = 8'h0c;
	localparam logic [AXI_AW-1:0] OFS_CONTROL   = 8'h10;
	localparam logic [AXI_AW-1:0] OFS_UNLOCK    = 8'h14;

	localparam logic [7:0]        UNLOCK_KEY1   = 8'h55;
	localparam logic [7:0]        UNLOCK_KEY2   = 8'haa;
	localparam logic [WORD_W-1:0] BLANK_WORD    = 14'h3fff;
	localparam logic [1:0]        RESP_OKAY     = 2'h0;
	localparam logic [1:0]        RESP_SLVERR   = 2'h2;

	localparam int unsigned PROG_TIME_NS     = 2000000;
	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned PROG_CYCLES_DEF  = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned TMR_W            = 18;

	// Control register layout, bit 0 is the read start
	typedef struct packed {
		logic cfg;
		logic erase;
		logic latch_only_select;
		logic err;
		logic permit;
		logic wr;
		logic rd;
	} pfsw_ctl_t;

	localparam pfsw_ctl_t CTL_RST = '0;

	typedef struct packed {
		logic              rd;
		logic              erase;
		logic              prog_we;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} pfsw_flash_t;

	typedef struct packed {
		logic force_nop;
		logic ignore_slot;
		logic stall;
	} pfsw_cpu_t;

	typedef logic [LATCH_N-1:0][WORD_W-1:0] pfsw_latch_arr_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_SLOT,
		ST_RD_FETCH,
		ST_WR_NOP1,
		ST_WR_NOP2,
		ST_ERASE,
		ST_PROG,
		ST_BUSY
	} pfsw_state_t;

	typedef enum logic [1:0] {
		UL_IDLE,
		UL_KEY1,
		UL_KEY2
	} pfsw_unlock_t;
endpackage
`default_nettype wire

/* pfsw_latch_bank.sv */
// Row of hidden program write latches, blank after reset and after each erase or program
`timescale 1ns/1ns
`default_nettype none
module pfsw_latch_bank (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      load,
	input  wire logic                      blank,
	input  wire logic [pfsw_pkg::LIDX_W-1:0] idx,
	input  wire logic [pfsw_pkg::WORD_W-1:0] wdata,
	output var  pfsw_pkg::pfsw_latch_arr_t words
);
	import pfsw_pkg::*;

	pfsw_latch_arr_t lat_q;
	pfsw_latch_arr_t lat_d;

	for (genvar i = 0; i < LATCH_N; i++)
	begin : g_lat
		always_comb
		begin
			lat_d[i] = lat_q[i];
			if (blank)
				lat_d[i] = BLANK_WORD;
			else if (load && idx == LIDX_W'(i))
				lat_d[i] = wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			lat_q <= {LATCH_N{BLANK_WORD}};
		else
			lat_q <= lat_d;
	end

	assign words = lat_q;
endmodule
`default_nettype wire

/* pfsw_flash_model.sv */
// Behavioural flash array that answers the self-write controller
`timescale 1ns/1ns
`default_nettype none
module pfsw_flash_model
	import pfsw_pkg::*;
(
	input  wire logic                  clk,
	input  wire pfsw_pkg::pfsw_flash_t req,
	output var  logic [WORD_W-1:0]     rdata
);
	logic [WORD_W-1:0] mem [1<<ADDR_W];
	logic [WORD_W-1:0] idle_q;
	initial
	begin
		idle_q = 14'h0;
		for (int i = 0; i < (1<<ADDR_W); i++)
			mem[i] = 14'(i) ^ 14'h1555;
	end
	always @(posedge clk)
	begin
		idle_q <= idle_q + 14'h1;
		if (req.erase) // Whole row blanks at once, never less
			for (int i = 0; i < 16; i++)
				mem[{req.addr[ADDR_W-1:4], 4'(i)}] <= BLANK_WORD;
		if (req.prog_we)
			mem[req.addr] <= req.wdata;
	end
	// Unselected array shows a moving pattern so stale data cannot pass
	assign rdata = req.rd ? mem[req.addr] : idle_q;
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the flash self-write controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import pfsw_pkg::*;
	localparam int unsigned PC = 20;
	logic              CLOCK, SYS_RST, PWR_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
	logic              S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY;
	logic              S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [7:0]        S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0]       S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0]        S_AXI_WSTRB;
	logic [1:0]        S_AXI_BRESP, S_AXI_RRESP;
	pfsw_flash_t       FLASH_REQ;
	pfsw_cpu_t         CPU_CTL;
	logic [WORD_W-1:0] FLASH_RDATA;
	logic [15:0][13:0] lat;
	int                error_cnt = 0;
	int                compares = 0;

	pfsw_top #(.PROG_CYCLES(PC)) dut (
		.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PWR_RST(PWR_RST),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
		.S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY), .FLASH_REQ(FLASH_REQ),
		.FLASH_RDATA(FLASH_RDATA), .CPU_CTL(CPU_CTL)
	);
	pfsw_flash_model u_flash (.clk(CLOCK), .req(FLASH_REQ), .rdata(FLASH_RDATA));

	initial
	begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end

	task automatic summarize;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
		logic ta, tw, tb;
		@(posedge CLOCK);
		S_AXI_AWADDR <= a;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WDATA <= {24'h0, d};
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do
		begin
			@(negedge CLOCK);
			ta = S_AXI_AWVALID && S_AXI_AWREADY;
			tw = S_AXI_WVALID && S_AXI_WREADY;
			tb = S_AXI_BVALID;
			if (tb)
				chk(32'(S_AXI_BRESP), 32'(r));
			@(posedge CLOCK);
			if (ta)
				S_AXI_AWVALID <= 1'b0;
			if (tw)
				S_AXI_WVALID <= 1'b0;
		end while (!tb);
		S_AXI_BREADY <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
		input logic [1:0] r = RESP_OKAY);
		logic ta, tr;
		@(posedge CLOCK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do
		begin
			@(negedge CLOCK);
			ta = S_AXI_ARVALID && S_AXI_ARREADY;
			tr = S_AXI_RVALID;
			if (tr)
				chk(S_AXI_RDATA & m, e);
			if (tr)
				chk(32'(S_AXI_RRESP), 32'(r));
			@(posedge CLOCK);
			if (ta)
				S_AXI_ARVALID <= 1'b0;
		end while (!tr);
		S_AXI_RREADY <= 1'b0;
	endtask

	task automatic set_pair(input logic [7:0] lo, input logic [13:0] v);
		wr(lo, v[7:0]);
		wr(lo + 8'h04, {2'b0, v[13:8]});
	endtask

	// Leaves the caller in the second cycle after the start write fired
	// Nothing else touches the bus between keys and start, as masked interrupts would
	task automatic start(input logic [7:0] c, input logic ul);
		if (ul)
			wr(OFS_UNLOCK, UNLOCK_KEY1);
		if (ul)
			wr(OFS_UNLOCK, UNLOCK_KEY2);
		wr(OFS_CONTROL, c);
		@(negedge CLOCK);
	endtask

	task automatic rword(input logic [13:0] a, input logic [13:0] e);
		set_pair(OFS_ADDR_LOW, a);
		start(8'h01, 1'b0); // The pair is fetched in the second slot, which is ignored
		chk(32'(FLASH_REQ.rd), 32'h1);
		chk(32'(FLASH_REQ.addr), 32'(a));
		chk(32'(CPU_CTL.ignore_slot), 32'h1);
		rd(OFS_DATA_LOW, 32'(e[7:0]));
		rd(OFS_DATA_HIGH, 32'(e[13:8]));
		rd(OFS_CONTROL, 32'h0);
	endtask

	task automatic quick(input logic [7:0] c, input logic ul, input logic fn);
		start(c, ul);
		chk(32'(CPU_CTL.force_nop), 32'(fn));
		@(negedge CLOCK);
		chk(32'(CPU_CTL.stall), 32'h0);
		chk(32'(FLASH_REQ), 32'h0);
		rd(OFS_CONTROL, 32'(c & 8'hfd));
	endtask

	task automatic wop(input logic [7:0] c, input logic [13:0] row, input logic er);
		int k = 0;
		int n = 0;
		start(c, 1'b1);
		chk(32'(CPU_CTL.force_nop), 32'h1);
		@(negedge CLOCK);
		chk(32'(FLASH_REQ.erase), 32'(er));
		if (er)
			chk(32'(FLASH_REQ.addr), 32'({row[13:4], 4'h0}));
		while (CPU_CTL.stall === 1'b1 && n < 500)
		begin
			if (FLASH_REQ.prog_we === 1'b1)
			begin
				chk(32'(FLASH_REQ.addr), 32'({row[13:4], 4'(k)}));
				chk(32'(FLASH_REQ.wdata), 32'(lat[k[3:0]]));
				k++;
			end
			n++;
			@(negedge CLOCK);
		end
		chk(n, er ? 1 + PC : 16 + PC);
		chk(k, er ? 0 : 16);
		rd(OFS_CONTROL, 32'(c & 8'hfd));
	endtask

	initial
	begin
		repeat (6000) @(posedge CLOCK);
		error_cnt++;
		$display("ERROR t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
		summarize();
	end

	initial
	begin
		{SYS_RST, PWR_RST} = 2'b11;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
		S_AXI_WSTRB = 4'hf;
		repeat (4) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		PWR_RST <= 1'b0;
		rd(OFS_CONTROL, 32'h0);
		wr(OFS_UNLOCK, UNLOCK_KEY1);
		rd(OFS_UNLOCK, 32'h0);
		wr(8'h18, 8'h01, RESP_SLVERR);
		rd(8'h18, 32'h0, '1, RESP_SLVERR);
		$display("test reset done");
		rword(14'h2a34, 14'h2a34 ^ 14'h1555);
		rd(OFS_ADDR_HIGH, 32'h2a);
		wr(OFS_CONTROL, 8'h04);
		rd(OFS_DATA_LOW, 32'h61);
		$display("test read done");
		quick(8'h06, 1'b0, 1'b0);
		wr(OFS_UNLOCK, UNLOCK_KEY1);
		set_pair(OFS_ADDR_LOW, 14'h0123);
		wr(OFS_UNLOCK, UNLOCK_KEY2);
		quick(8'h06, 1'b0, 1'b0);
		quick(8'h02, 1'b1, 1'b1);
		$display("test unlock done");
		set_pair(OFS_DATA_LOW, 14'h1abc);
		quick(8'h16, 1'b1, 1'b1);
		set_pair(OFS_ADDR_LOW, 14'h012f);
		set_pair(OFS_DATA_LOW, 14'h0555);
		quick(8'h16, 1'b1, 1'b1);
		lat = {16{BLANK_WORD}};
		lat[3] = 14'h1abc;
		lat[15] = 14'h0555;
		wop(8'h06, 14'h0120, 1'b0);
		rword(14'h0123, 14'h1abc);
		lat = {16{BLANK_WORD}};
		wop(8'h06, 14'h0120, 1'b0);
		$display("test program done");
		set_pair(OFS_ADDR_LOW, 14'h0127);
		wop(8'h26, 14'h0127, 1'b1); // Row erased from a mid-row address after its rewrite
		rword(14'h0123, BLANK_WORD);
		rword(14'h0130, 14'h0130 ^ 14'h1555);
		$display("test erase done");
		set_pair(OFS_ADDR_LOW, 14'h0140);
		start(8'h26, 1'b1);
		@(posedge CLOCK);
		SYS_RST <= 1'b1;
		repeat (2) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		@(negedge CLOCK);
		chk(32'(CPU_CTL), 32'h0);
		rd(OFS_CONTROL, 32'h08, 32'h0e);
		@(posedge CLOCK);
		PWR_RST <= 1'b1;
		@(posedge CLOCK);
		PWR_RST <= 1'b0;
		rd(OFS_CONTROL, 32'h0);
		$display("test reset error done");
		summarize();
	end
endmodule
`default_nettype wire
